// *** core/pfbo_pkg.sv ***
package pfbo_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_FAULT_B_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_OVERRIDE_CONTROL = 8'h04;
  localparam logic [7:0] OFS_DUTY_ONE         = 8'h08;
  localparam logic [7:0] OFS_DUTY_TWO         = 8'h0c;
  localparam logic [7:0] OFS_DUTY_THREE       = 8'h10;
  localparam logic [7:0] OFS_FAULT_STATUS     = 8'h14;
  localparam logic [7:0] OFS_UPDATE_CONTROL   = 8'h18;

  // Implemented bits and reset values
  localparam logic [15:0] FAULT_B_MASK    = 16'h3f87;
  localparam logic [15:0] FAULT_B_RESET   = 16'h0007;
  localparam logic [15:0] OVERRIDE_MASK   = 16'h3f3f;
  localparam logic [15:0] OVERRIDE_RESET  = 16'h3f00;
  localparam logic [15:0] DUTY_RESET      = 16'h0000;
  localparam logic [15:0] UPDATE_MASK     = 16'h0006;
  localparam logic [15:0] UPDATE_RESET    = 16'h0000;

  // Field positions
  localparam int FAULT_LEVEL_LSB   = 8;
  localparam int FAULT_MODE_BIT    = 7;
  localparam int GEN_SELECT_LSB    = 8;
  localparam int MANUAL_LEVEL_LSB  = 0;
  localparam int OVERRIDE_SYNC_BIT = 1;
  localparam int IMMEDIATE_BIT     = 2;
  localparam int STATUS_ACTIVE_BIT = 0;
  localparam int STATUS_RAW_BIT    = 1;
  localparam int NUM_PAIRS         = 3;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY = 1'h0;

  // Fault state encoding
  typedef enum logic [1:0] {FAULT_IDLE, FAULT_LATCHED, FAULT_CYCLE} pfbo_fault_type;

endpackage : pfbo_pkg

// *** core/pfbo_fault_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface pfbo_fault_if;
  logic ce;            // Clock enable
  logic cycleMode;     // Cycle-by-cycle when high
  logic clearLatch;    // Software clear of latched fault
  logic timeBaseSync;  // PWM period boundary pulse
  logic faultActive;   // Override in force
  logic faultRaw;      // Filtered fault pin, active high

  modport ctrl (input ce, cycleMode, clearLatch, timeBaseSync, output faultActive, faultRaw);
  modport core (output ce, cycleMode, clearLatch, timeBaseSync, input faultActive, faultRaw);
endinterface : pfbo_fault_if
`default_nettype wire

// *** core/pfbo_fault_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module pfbo_fault_ctrl (
  input  wire logic     clk,         // System clock
  input  wire logic     rst,         // Async reset, active high
  input  wire logic     faultPin_n,  // Fault B pin, active low
  pfbo_fault_if.ctrl    fif          // Fault control link
);

  logic           syncOne;
  logic           syncTwo;
  logic           syncThree;
  logic           pinFiltered_n;
  pfbo_pkg::pfbo_fault_type state;

  // Three-stage pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncOne   <= 1'h1;
      syncTwo   <= 1'h1;
      syncThree <= 1'h1;
    end else if (fif.ce) begin
      syncOne   <= faultPin_n;
      syncTwo   <= syncOne;
      syncThree <= syncTwo;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinFiltered_n <= 1'h1;
    end else if (fif.ce && (syncTwo == syncThree)) begin
      pinFiltered_n <= syncTwo;
    end
  end

  assign fif.faultRaw    = ~pinFiltered_n;
  assign fif.faultActive = (state != pfbo_pkg::FAULT_IDLE);

  // Fault state: a present fault always wins over a release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pfbo_pkg::FAULT_IDLE;
    end else if (fif.ce) begin
      case (state)
        pfbo_pkg::FAULT_IDLE: begin
          if (fif.faultRaw) begin
            state <= fif.cycleMode ? pfbo_pkg::FAULT_CYCLE : pfbo_pkg::FAULT_LATCHED;
          end
        end
        pfbo_pkg::FAULT_LATCHED: begin
          if (fif.clearLatch && !fif.faultRaw) begin
            state <= pfbo_pkg::FAULT_IDLE;
          end
        end
        pfbo_pkg::FAULT_CYCLE: begin
          if (fif.timeBaseSync && !fif.faultRaw) begin
            state <= pfbo_pkg::FAULT_IDLE;
          end
        end
        default: begin
          state <= pfbo_pkg::FAULT_IDLE;
        end
      endcase
    end
  end

endmodule : pfbo_fault_ctrl
`default_nettype wire

// *** core/pfbo_top.sv ***
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
module pfbo_top #(
  parameter int DUTY_WIDTH = 16   // Duty value width
) (
  input  wire logic                  clk,              // System clock
  input  wire logic                  rst,              // Async reset, active high
  input  wire logic                  ce,               // Clock enable, freezes state
  input  wire logic                  hsel,             // AHB slave select
  input  wire logic [31:0]           haddr,            // AHB address
  input  wire logic [1:0]            htrans,           // AHB transfer type
  input  wire logic                  hwrite,           // AHB write
  input  wire logic [2:0]            hsize,            // AHB size
  input  wire logic [31:0]           hwdata,           // AHB write data
  input  wire logic                  hready,           // AHB bus ready
  output logic                       hreadyout,        // AHB slave ready
  output logic [31:0]                hrdata,           // AHB read data
  output logic                       hresp,            // AHB response
  input  wire logic                  writeLockConfig,  // Lock configuration bit
  input  wire logic                  writeUnlocked,    // Unlock sequence accepted
  input  wire logic                  faultBPin_n,      // Fault B pin, active low
  input  wire logic                  timeBaseSync,     // PWM period boundary pulse
  input  wire logic [2:0]            genHigh,          // Generator high-side levels
  input  wire logic [2:0]            genLow,           // Generator low-side levels
  output logic [2:0]                 highSideOutput,   // High-side pins
  output logic [2:0]                 lowSideOutput,    // Low-side pins
  output logic [DUTY_WIDTH-1:0]      dutyActiveOne,    // Active duty one
  output logic [DUTY_WIDTH-1:0]      dutyActiveTwo,    // Active duty two
  output logic [DUTY_WIDTH-1:0]      dutyActiveThree,  // Active duty three
  output logic                       faultBActive      // Fault override in force
);

  logic [15:0]           faultCtl;
  logic [15:0]           overrideCtl;
  logic [15:0]           overrideActive;
  logic [15:0]           updateCtl;
  logic [DUTY_WIDTH-1:0] dutyOne;
  logic [DUTY_WIDTH-1:0] dutyTwo;
  logic [DUTY_WIDTH-1:0] dutyThree;
  logic                  wrPending;
  logic [7:0]            wrAddr;
  logic                  addrPhase;
  logic                  faultWriteOk;
  logic                  clearLatch;
  logic [2:0]            next_high;
  logic [2:0]            next_low;

  pfbo_fault_if fif ();

  // Write offset match for the data phase
  function automatic logic wrHit(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
    return pend && (a == ofs);
  endfunction : wrHit

  // Pin source: fault level, generator or manual level
  function automatic logic pinLevel(input logic faultOn, input logic faultLevel,
                                    input logic genSel, input logic genVal,
                                    input logic manVal);
    return faultOn ? faultLevel : (genSel ? genVal : manVal);
  endfunction : pinLevel

  // Read mux of all registers
  function automatic logic [15:0] readMux(input logic [7:0] a);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      pfbo_pkg::OFS_FAULT_B_CONTROL:  r = faultCtl & pfbo_pkg::FAULT_B_MASK;
      pfbo_pkg::OFS_OVERRIDE_CONTROL: r = overrideCtl & pfbo_pkg::OVERRIDE_MASK;
      pfbo_pkg::OFS_DUTY_ONE:         r = 16'(dutyOne);
      pfbo_pkg::OFS_DUTY_TWO:         r = 16'(dutyTwo);
      pfbo_pkg::OFS_DUTY_THREE:       r = 16'(dutyThree);
      pfbo_pkg::OFS_FAULT_STATUS: begin
        r[pfbo_pkg::STATUS_ACTIVE_BIT] = fif.faultActive;
        r[pfbo_pkg::STATUS_RAW_BIT]    = fif.faultRaw;
      end
      pfbo_pkg::OFS_UPDATE_CONTROL:   r = updateCtl & pfbo_pkg::UPDATE_MASK;
      default:                        r = 16'h0000;
    endcase
    return r;
  endfunction : readMux

  // Fault handling only sees the dedicated pin
  assign fif.ce           = ce;
  assign fif.cycleMode    = faultCtl[pfbo_pkg::FAULT_MODE_BIT];
  assign fif.clearLatch   = clearLatch;
  assign fif.timeBaseSync = timeBaseSync;

  pfbo_fault_ctrl i_pfbo_fault_ctrl (
    .clk        (clk),
    .rst        (rst),
    .faultPin_n (faultBPin_n),
    .fif        (fif)
  );

  // Address phase of a whole-word transfer
  assign addrPhase = hsel && (htrans == pfbo_pkg::HTRANS_NONSEQ) && hready && ce
                     && (hsize == pfbo_pkg::HSIZE_WORD);
  assign faultWriteOk = !writeLockConfig || writeUnlocked;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'h1;
      hresp     <= pfbo_pkg::HRESP_OKAY;
      hrdata    <= 32'h00000000;
      wrPending <= 1'h0;
      wrAddr    <= 8'h00;
    end else if (ce) begin
      hreadyout <= 1'h1;
      hresp     <= pfbo_pkg::HRESP_OKAY;
      wrPending <= addrPhase && hwrite;
      wrAddr    <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata <= {16'h0000, readMux(haddr[7:0])};
      end
    end
  end

  // Fault B control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      faultCtl <= pfbo_pkg::FAULT_B_RESET;
    end else if (ce && faultWriteOk && wrHit(wrPending, wrAddr, pfbo_pkg::OFS_FAULT_B_CONTROL)) begin
      faultCtl <= hwdata[15:0] & pfbo_pkg::FAULT_B_MASK;
    end
  end

  // Override control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrideCtl <= pfbo_pkg::OVERRIDE_RESET;
    end else if (ce && wrHit(wrPending, wrAddr, pfbo_pkg::OFS_OVERRIDE_CONTROL)) begin
      overrideCtl <= hwdata[15:0] & pfbo_pkg::OVERRIDE_MASK;
    end
  end

  // Update control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      updateCtl <= pfbo_pkg::UPDATE_RESET;
    end else if (ce && wrHit(wrPending, wrAddr, pfbo_pkg::OFS_UPDATE_CONTROL)) begin
      updateCtl <= hwdata[15:0] & pfbo_pkg::UPDATE_MASK;
    end
  end

  // Duty value registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dutyOne   <= DUTY_WIDTH'(pfbo_pkg::DUTY_RESET);
      dutyTwo   <= DUTY_WIDTH'(pfbo_pkg::DUTY_RESET);
      dutyThree <= DUTY_WIDTH'(pfbo_pkg::DUTY_RESET);
    end else if (ce) begin
      if (wrHit(wrPending, wrAddr, pfbo_pkg::OFS_DUTY_ONE)) begin
        dutyOne <= hwdata[DUTY_WIDTH-1:0];
      end
      if (wrHit(wrPending, wrAddr, pfbo_pkg::OFS_DUTY_TWO)) begin
        dutyTwo <= hwdata[DUTY_WIDTH-1:0];
      end
      if (wrHit(wrPending, wrAddr, pfbo_pkg::OFS_DUTY_THREE)) begin
        dutyThree <= hwdata[DUTY_WIDTH-1:0];
      end
    end
  end

  // Latched-fault clear pulse from a status write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clearLatch <= 1'h0;
    end else if (ce) begin
      clearLatch <= wrHit(wrPending, wrAddr, pfbo_pkg::OFS_FAULT_STATUS)
                    && hwdata[pfbo_pkg::STATUS_ACTIVE_BIT];
    end
  end

  // Active override copy, immediate or on the time base
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrideActive <= pfbo_pkg::OVERRIDE_RESET;
    end else if (ce && (!updateCtl[pfbo_pkg::OVERRIDE_SYNC_BIT] || timeBaseSync)) begin
      overrideActive <= overrideCtl;
    end
  end

  // Active duty values, immediate or on the time base
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dutyActiveOne   <= DUTY_WIDTH'(pfbo_pkg::DUTY_RESET);
      dutyActiveTwo   <= DUTY_WIDTH'(pfbo_pkg::DUTY_RESET);
      dutyActiveThree <= DUTY_WIDTH'(pfbo_pkg::DUTY_RESET);
    end else if (ce && (updateCtl[pfbo_pkg::IMMEDIATE_BIT] || timeBaseSync)) begin
      dutyActiveOne   <= dutyOne;
      dutyActiveTwo   <= dutyTwo;
      dutyActiveThree <= dutyThree;
    end
  end

  // Per-pin source selection
  always_comb begin
    next_high = 3'h0;
    next_low  = 3'h0;
    for (int i = 0; i < pfbo_pkg::NUM_PAIRS; i++) begin
      next_high[i] = pinLevel(fif.faultActive && faultCtl[i],
                              faultCtl[pfbo_pkg::FAULT_LEVEL_LSB + 2*i + 1],
                              overrideActive[pfbo_pkg::GEN_SELECT_LSB + 2*i + 1],
                              genHigh[i],
                              overrideActive[pfbo_pkg::MANUAL_LEVEL_LSB + 2*i + 1]);
      next_low[i]  = pinLevel(fif.faultActive && faultCtl[i],
                              faultCtl[pfbo_pkg::FAULT_LEVEL_LSB + 2*i],
                              overrideActive[pfbo_pkg::GEN_SELECT_LSB + 2*i],
                              genLow[i],
                              overrideActive[pfbo_pkg::MANUAL_LEVEL_LSB + 2*i]);
    end
  end

  // Registered pin outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      highSideOutput <= 3'h0;
      lowSideOutput  <= 3'h0;
      faultBActive   <= 1'h0;
    end else if (ce) begin
      highSideOutput <= next_high;
      lowSideOutput  <= next_low;
      faultBActive   <= fif.faultActive;
    end
  end

  // Checks on the pin and register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fault_level;
    (ce && fif.faultActive && faultCtl[0]) |=> (highSideOutput[0] == $past(faultCtl[9]))
                                               && (lowSideOutput[0] == $past(faultCtl[8]));
  endproperty
  a_fault_level: assert property (p_fault_level) else $error("fault level not driven");

  property p_cycle_release;
    (ce && fif.cycleMode && fif.faultActive && timeBaseSync && !fif.faultRaw)
      |=> !fif.faultActive;
  endproperty
  a_cycle_release: assert property (p_cycle_release) else $error("cycle fault held");

  property p_latch_hold;
    (ce && !fif.cycleMode && fif.faultActive && !clearLatch) |=> fif.faultActive;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault dropped");

  property p_enable_reset;
    $past(rst) |-> (faultCtl[2:0] == 3'h7) && (overrideCtl[13:8] == 6'h3f);
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("bad reset value");

  property p_locked_write;
    (ce && writeLockConfig && !writeUnlocked && wrPending
     && (wrAddr == pfbo_pkg::OFS_FAULT_B_CONTROL)) |=> $stable(faultCtl);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write taken");

  property p_manual;
    (ce && !fif.faultActive && !overrideActive[9])
      |=> highSideOutput[0] == $past(overrideActive[1]);
  endproperty
  a_manual: assert property (p_manual) else $error("manual level wrong");

  property p_duty_write;
    (ce && wrPending && (wrAddr == pfbo_pkg::OFS_DUTY_ONE))
      |=> dutyOne == $past(hwdata[DUTY_WIDTH-1:0]);
  endproperty
  a_duty_write: assert property (p_duty_write) else $error("duty not stored");

  property p_reserved_read;
    (addrPhase && !hwrite && (haddr[7:0] == pfbo_pkg::OFS_FAULT_B_CONTROL))
      |=> (hrdata[15:14] == 2'h0) && (hrdata[6:3] == 4'h0);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits set");

  property p_immediate;
    (ce && updateCtl[2]) |=> dutyActiveTwo == $past(dutyTwo);
  endproperty
  a_immediate: assert property (p_immediate) else $error("duty not immediate");

  property p_pair_free;
    (ce && fif.faultActive && !faultCtl[2] && overrideActive[13])
      |=> highSideOutput[2] == $past(genHigh[2]);
  endproperty
  a_pair_free: assert property (p_pair_free) else $error("free pair overridden");

  // Enables, generator select, sync and write path
  property p_pair_enable;
    (ce && fif.faultActive && faultCtl[1])
      |=> (lowSideOutput[1] == $past(faultCtl[10]));
  endproperty
  a_pair_enable: assert property (p_pair_enable) else $error("pair enable ignored");

  property p_gen_select;
    (ce && !fif.faultActive && overrideActive[8])
      |=> (lowSideOutput[0] == $past(genLow[0]));
  endproperty
  a_gen_select: assert property (p_gen_select) else $error("generator not selected");

  property p_sync_hold;
    (ce && updateCtl[pfbo_pkg::OVERRIDE_SYNC_BIT] && !timeBaseSync)
      |=> $stable(overrideActive);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("override not held");

  property p_sync_apply;
    (ce && updateCtl[pfbo_pkg::OVERRIDE_SYNC_BIT] && timeBaseSync)
      |=> (overrideActive == $past(overrideCtl));
  endproperty
  a_sync_apply: assert property (p_sync_apply) else $error("override not applied");

  property p_write_open;
    (ce && faultWriteOk && wrPending && (wrAddr == pfbo_pkg::OFS_FAULT_B_CONTROL))
      |=> (faultCtl == ($past(hwdata[15:0]) & pfbo_pkg::FAULT_B_MASK));
  endproperty
  a_write_open: assert property (p_write_open) else $error("open write lost");

  property p_duty_hold;
    (ce && !updateCtl[pfbo_pkg::IMMEDIATE_BIT] && !timeBaseSync)
      |=> $stable(dutyActiveThree);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty moved early");

  c_latched: cover property (!fif.cycleMode && $rose(fif.faultActive));
  c_cycle: cover property (fif.cycleMode && $fell(fif.faultActive));
  c_locked: cover property (writeLockConfig && !writeUnlocked && wrPending);
  c_manual: cover property (!overrideActive[8] && overrideActive[0]);
  c_sync: cover property (updateCtl[pfbo_pkg::OVERRIDE_SYNC_BIT] && timeBaseSync);

endmodule : pfbo_top
`default_nettype wire

// *** dv/pfbo_power_stage.sv ***
`timescale 1ns/10ps
`default_nettype none
module pfbo_power_stage (
  input  wire logic       clk,         // System clock
  input  wire logic [2:0] highSide,    // High-side gate commands
  input  wire logic [2:0] lowSide,     // Low-side gate commands
  input  wire logic       trip,        // Overcurrent event from bench
  output logic            faultPin_n   // Dedicated fault line, active low
);
  // Trip pulls the dedicated fault line low, else pulled up high
  always_ff @(posedge clk) begin
    faultPin_n <= !trip;
  end
endmodule : pfbo_power_stage
`default_nettype wire

// *** dv/test_pfbo_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_pfbo_top;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, timeBaseSync, trip, faultPin_n;
  logic        writeLockConfig, writeUnlocked, faultBActive, ce;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, genHigh, genLow, highSideOutput, lowSideOutput;
  logic [15:0] dutyActiveOne, dutyActiveTwo, dutyActiveThree;
  int          errCount, checked;

  pfbo_top #(.DUTY_WIDTH(16)) i_pfbo_top (
    .clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .writeLockConfig(writeLockConfig), .writeUnlocked(writeUnlocked),
    .faultBPin_n(faultPin_n), .timeBaseSync(timeBaseSync), .genHigh(genHigh),
    .genLow(genLow), .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
    .dutyActiveOne(dutyActiveOne), .dutyActiveTwo(dutyActiveTwo),
    .dutyActiveThree(dutyActiveThree), .faultBActive(faultBActive));

  pfbo_power_stage i_pfbo_power_stage (
    .clk(clk), .highSide(highSideOutput), .lowSide(lowSideOutput), .trip(trip),
    .faultPin_n(faultPin_n));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end

  // Verdict and end of run
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrapUp

  // Compare and count
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      errCount++;
    end
  endtask : check

  // Wait for slave ready at a rising edge
  task automatic waitReady();
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : waitReady

  task automatic busWrite(input logic [7:0] addr, input logic [31:0] data);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, addr};
    hwrite <= 1'b1;
    htrans <= pfbo_pkg::HTRANS_NONSEQ;
    hsize  <= pfbo_pkg::HSIZE_WORD;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= data;
    waitReady();
  endtask : busWrite

  task automatic busRead(input logic [7:0] addr, output logic [31:0] data);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, addr};
    hwrite <= 1'b0;
    htrans <= pfbo_pkg::HTRANS_NONSEQ;
    hsize  <= pfbo_pkg::HSIZE_WORD;
    waitReady();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    waitReady();
    data = hrdata;
  endtask : busRead

  // Read a register and compare
  task automatic readCheck(input string name, input logic [7:0] addr, input logic [31:0] exp);
    busRead(addr, rdata);
    check(name, exp, rdata);
  endtask : readCheck

  // One period boundary pulse, then settle
  task automatic syncPulse();
    timeBaseSync <= 1'b1;
    @(posedge clk);
    timeBaseSync <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : syncPulse

  // Expected pins as {high, low} from register contents
  function automatic logic [5:0] expPins(input logic [15:0] ovr, input logic [15:0] flt,
                                         input logic fault);
    logic [5:0] r;
    for (int i = 0; i < 3; i++) begin
      r[3+i] = ovr[9+2*i] ? genHigh[i] : ovr[1+2*i];
      r[i]   = ovr[8+2*i] ? genLow[i] : ovr[2*i];
      if (fault && flt[i]) begin
        r[3+i] = flt[9+2*i];
        r[i]   = flt[8+2*i];
      end
    end
    return r;
  endfunction : expPins

  task automatic pinCheck(input string name, input logic [5:0] exp);
    check(name, {26'h0, exp}, {26'h0, highSideOutput, lowSideOutput});
  endtask : pinCheck

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    $display("watchdog expired");
    wrapUp();
  end

  // Test sequence
  initial begin
    errCount = 0;
    checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    timeBaseSync = 1'b0;
    trip = 1'b0;
    writeLockConfig = 1'b0;
    writeUnlocked = 1'b0;
    genHigh = 3'h5;
    genLow = 3'h2;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    readCheck("fault ctl reset", pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00000007);
    readCheck("override reset", pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'h00003f00);
    for (int k = 0; k < 3; k++) begin
      readCheck("duty reset", 8'h08 + 8'(4 * k), 32'h00000000);
    end
    readCheck("unmapped", 8'h1c, 32'h00000000);
    check("hresp okay", 32'h0, {31'h0, hresp});
    pinCheck("pins at reset", expPins(16'h3f00, 16'h0007, 1'b0));
    $display("test reset values done");

    busWrite(pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'hffffffff);
    readCheck("override mask", pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'h00003f3f);
    busWrite(pfbo_pkg::OFS_FAULT_B_CONTROL, 32'hffffffff);
    readCheck("fault ctl mask", pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00003f87);
    busWrite(pfbo_pkg::OFS_UPDATE_CONTROL, 32'h00000000);
    for (int k = 0; k < 3; k++) begin
      busWrite(8'h08 + 8'(4 * k), 32'habcd1234 + 32'(k * 16'h1111));
      readCheck("duty value", 8'h08 + 8'(4 * k), 32'h00001234 + 32'(k * 16'h1111));
    end
    check("duty held", 32'h0, {16'h0, dutyActiveOne});
    syncPulse();
    check("duty one", 32'h1234, {16'h0, dutyActiveOne});
    check("duty two", 32'h2345, {16'h0, dutyActiveTwo});
    check("duty three", 32'h3456, {16'h0, dutyActiveThree});
    busWrite(pfbo_pkg::OFS_UPDATE_CONTROL, 32'h00000004);
    busWrite(pfbo_pkg::OFS_DUTY_ONE, 32'h0000beef);
    repeat (3) @(posedge clk);
    check("duty immediate", 32'hbeef, {16'h0, dutyActiveOne});
    ce <= 1'b0;
    busWrite(pfbo_pkg::OFS_DUTY_ONE, 32'h00000001);
    ce <= 1'b1;
    readCheck("frozen write", pfbo_pkg::OFS_DUTY_ONE, 32'h0000beef);
    $display("test registers and duty done");

    busWrite(pfbo_pkg::OFS_UPDATE_CONTROL, 32'h00000000);
    busWrite(pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'h00000027);
    repeat (3) @(posedge clk);
    pinCheck("manual pins", expPins(16'h0027, 16'h0000, 1'b0));
    busWrite(pfbo_pkg::OFS_UPDATE_CONTROL, 32'h00000002);
    busWrite(pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'h00003f00);
    repeat (3) @(posedge clk);
    pinCheck("sync held", expPins(16'h0027, 16'h0000, 1'b0));
    syncPulse();
    pinCheck("sync applied", expPins(16'h3f00, 16'h0000, 1'b0));
    $display("test override done");

    busWrite(pfbo_pkg::OFS_UPDATE_CONTROL, 32'h00000000);
    busWrite(pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'h00003c01);
    busWrite(pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00002603);
    trip <= 1'b1;
    repeat (10) @(posedge clk);
    pinCheck("latched fault", expPins(16'h3c01, 16'h2603, 1'b1));
    readCheck("status active", pfbo_pkg::OFS_FAULT_STATUS, 32'h00000003);
    check("fault flag", 32'h1, {31'h0, faultBActive});
    trip <= 1'b0;
    repeat (10) @(posedge clk);
    pinCheck("latch holds", expPins(16'h3c01, 16'h2603, 1'b1));
    busWrite(pfbo_pkg::OFS_FAULT_STATUS, 32'h00000001);
    repeat (5) @(posedge clk);
    pinCheck("latch cleared", expPins(16'h3c01, 16'h2603, 1'b0));
    check("fault flag off", 32'h0, {31'h0, faultBActive});
    $display("test latched fault done");

    busWrite(pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00002687);
    trip <= 1'b1;
    repeat (10) @(posedge clk);
    pinCheck("cycle fault", expPins(16'h3c01, 16'h2687, 1'b1));
    trip <= 1'b0;
    repeat (10) @(posedge clk);
    pinCheck("cycle hold", expPins(16'h3c01, 16'h2687, 1'b1));
    syncPulse();
    pinCheck("cycle release", expPins(16'h3c01, 16'h2687, 1'b0));
    $display("test cycle fault done");

    writeLockConfig <= 1'b1;
    busWrite(pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00000000);
    readCheck("locked write", pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00002687);
    writeUnlocked <= 1'b1;
    busWrite(pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00000000);
    readCheck("unlocked write", pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00000000);
    writeLockConfig <= 1'b0;
    writeUnlocked <= 1'b0;
    $display("test write lock done");

    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    readCheck("enable after reset", pfbo_pkg::OFS_FAULT_B_CONTROL, 32'h00000007);
    readCheck("override after reset", pfbo_pkg::OFS_OVERRIDE_CONTROL, 32'h00003f00);
    $display("test second reset done");
    wrapUp();
  end
endmodule : test_pfbo_top
`default_nettype wire
